// file: tmr16_defines.vh
`ifndef TMR16_DEFINES_VH
`define TMR16_DEFINES_VH

// Register byte offsets on the AHB-Lite slave.
`define TMR16_OFS_CTRL 8'h00
`define TMR16_OFS_CMP_LO 8'h04
`define TMR16_OFS_CMP_HI 8'h08
`define TMR16_OFS_SEC_LO 8'h0C
`define TMR16_OFS_SEC_HI 8'h10
`define TMR16_OFS_CMP_W 8'h14
`define TMR16_OFS_SEC_W 8'h18
`define TMR16_OFS_STAT 8'h1C

// Control register field positions and reset value.
`define TMR16_MODE_LSB 0
`define TMR16_MODE_MSB 2
`define TMR16_CK_LSB 3
`define TMR16_CK_MSB 4
`define TMR16_START_LSB 5
`define TMR16_START_MSB 6
`define TMR16_ACAP_BIT 7
`define TMR16_METT_BIT 8
`define TMR16_TFF_BIT 9
`define TMR16_PSEL_BIT 10
`define TMR16_CTRL_W 11
`define TMR16_CTRL_RST 11'h000

// Status register field positions.
`define TMR16_STAT_RUN_BIT 16
`define TMR16_STAT_CPEND_BIT 17
`define TMR16_STAT_SPEND_BIT 18

// Mode field encodings.
`define TMR16_M_TIMER 3'h0
`define TMR16_M_EXTTRIG 3'h1
`define TMR16_M_EVENT 3'h2
`define TMR16_M_WINDOW 3'h3
`define TMR16_M_PWIDTH 3'h4
`define TMR16_M_PULSE 3'h5

// Start control field encodings.
`define TMR16_S_STOP 2'h0
`define TMR16_S_RISE 2'h1
`define TMR16_S_FALL 2'h2
`define TMR16_S_RISE2 2'h3

// Prescaler: log2 of divide ratio per source clock select value.
`define TMR16_DIV_SH0 4'hB
`define TMR16_DIV_SH1 4'h7
`define TMR16_DIV_SH2 4'h3
`define TMR16_DIV_SH3 4'h0
`define TMR16_PRE_W 13

// Noise filter, times in high_freq_clock periods (hclk is that clock).
`define TMR16_REJECT_FC 4
`define TMR16_DETECT_FC 12
`define TMR16_FILT_CYC ((`TMR16_REJECT_FC + `TMR16_DETECT_FC) / 2)
`define TMR16_FILT_W 4

`endif

// file: tmr16_prescale.v
`timescale 1ns/100ps
`include "tmr16_defines.vh"

module tmr16_prescale (
	input wire hclk,
	input wire hresetn,
	input wire [1:0] source_clock_select,
	input wire prescaler_select,
	output wire tick
);
	reg [`TMR16_PRE_W-1:0] div_ff;
	reg [3:0] shift;
	wire [`TMR16_PRE_W-1:0] mask;

	// Divide ratio is a power of two; prescaler_select doubles it.
	always @* begin
		case (source_clock_select)
			2'h0: shift = `TMR16_DIV_SH0;
			2'h1: shift = `TMR16_DIV_SH1;
			2'h2: shift = `TMR16_DIV_SH2;
			default: shift = `TMR16_DIV_SH3;
		endcase
		shift = shift + {3'h0, prescaler_select};
	end

	assign mask = ({{(`TMR16_PRE_W-1){1'b0}}, 1'b1} << shift) - {{(`TMR16_PRE_W-1){1'b0}}, 1'b1};

	// Free-running divider, so a changed select takes effect at once.
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			div_ff <= {`TMR16_PRE_W{1'b0}};
		end else begin
			div_ff <= div_ff + {{(`TMR16_PRE_W-1){1'b0}}, 1'b1};
		end
	end

	assign tick = ((div_ff & mask) == mask);
endmodule

// file: tmr16_pinfilt.v
`timescale 1ns/100ps
`include "tmr16_defines.vh"

module tmr16_pinfilt (
	input wire hclk,
	input wire hresetn,
	input wire pin,
	output wire level,
	output wire rise,
	output wire fall
);
	reg sync1_ff;
	reg sync2_ff;
	reg level_ff;
	reg rise_ff;
	reg fall_ff;
	reg [`TMR16_FILT_W-1:0] cnt_ff;
	wire differ;

	// Two-stage synchroniser; only the second stage feeds the filter.
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sync1_ff <= 1'b0;
			sync2_ff <= 1'b0;
		end else begin
			sync1_ff <= pin;
			sync2_ff <= sync1_ff;
		end
	end

	assign differ = (sync2_ff != level_ff);

	// A new level must persist for the filter count before it is accepted.
	// Short glitches restart the count, so they never reach the counter.
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt_ff <= {`TMR16_FILT_W{1'b0}};
			level_ff <= 1'b0;
			rise_ff <= 1'b0;
			fall_ff <= 1'b0;
		end else begin
			rise_ff <= 1'b0;
			fall_ff <= 1'b0;
			if (!differ) begin
				cnt_ff <= {`TMR16_FILT_W{1'b0}};
			end else if (cnt_ff == `TMR16_FILT_CYC - 1) begin
				cnt_ff <= {`TMR16_FILT_W{1'b0}};
				level_ff <= sync2_ff;
				rise_ff <= sync2_ff;
				fall_ff <= ~sync2_ff;
			end else begin
				cnt_ff <= cnt_ff + {{(`TMR16_FILT_W-1){1'b0}}, 1'b1};
			end
		end
	end

	assign level = level_ff;
	assign rise = rise_ff;
	assign fall = fall_ff;
endmodule

// file: tmr16_top.v
// The AHB-Lite slave port and the address map are this design's own decisions.
`timescale 1ns/100ps
`include "tmr16_defines.vh"

module tmr16_top (
	input wire hclk,
	input wire hresetn,
	input wire hsel,
	input wire [7:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	output wire hreadyout,
	output wire [31:0] hrdata,
	output wire hresp,
	input wire timer_input_pin,
	input wire stop_mode_req,
	output wire match_interrupt
);
	reg [`TMR16_CTRL_W-1:0] ctrl_ff;
	reg [15:0] cnt_ff;
	reg run_ff;
	reg irq_ff;
	reg [15:0] cmp_buf_ff;
	reg [15:0] cmp_act_ff;
	reg cmp_pend_ff;
	reg [15:0] sec_buf_ff;
	reg [15:0] sec_act_ff;
	reg sec_pend_ff;
	reg [31:0] rdata_ff;
	reg wr_ff;
	reg [7:0] waddr_ff;
	reg [15:0] nxt_cnt;
	reg nxt_run;
	reg nxt_irq;
	reg cap_ev;
	reg [31:0] nxt_rdata;
	wire tick;
	wire pin_level;
	wire pin_rise;
	wire pin_fall;
	wire [2:0] mode;
	wire [1:0] start;
	wire acap;
	wire mett;
	wire running;
	wire trig_rise;
	wire trig_edge;
	wire opp_edge;
	wire at_match;
	wire cap_mode;
	wire [15:0] cnt_inc;
	wire addr_phase;
	wire wr_ctrl;
	wire wr_cmp_lo;
	wire wr_cmp_hi;
	wire wr_sec_lo;
	wire wr_sec_hi;
	wire wr_cmp_w;
	wire wr_sec_w;

	assign mode = ctrl_ff[`TMR16_MODE_MSB:`TMR16_MODE_LSB];
	assign start = ctrl_ff[`TMR16_START_MSB:`TMR16_START_LSB];
	assign acap = ctrl_ff[`TMR16_ACAP_BIT];
	assign mett = ctrl_ff[`TMR16_METT_BIT];
	assign running = (start != `TMR16_S_STOP);
	assign trig_rise = (start != `TMR16_S_FALL);
	assign trig_edge = trig_rise ? pin_rise : pin_fall;
	assign opp_edge = trig_rise ? pin_fall : pin_rise;
	assign at_match = (cnt_ff == cmp_act_ff);
	assign cnt_inc = cnt_ff + 16'h0001;
	assign cap_mode = (mode == `TMR16_M_TIMER) || (mode == `TMR16_M_EVENT) ||
		(mode == `TMR16_M_WINDOW);

	// Source clock tick from the shared prescaler.
	tmr16_prescale u_pre (
		.hclk(hclk),
		.hresetn(hresetn),
		.source_clock_select(ctrl_ff[`TMR16_CK_MSB:`TMR16_CK_LSB]),
		.prescaler_select(ctrl_ff[`TMR16_PSEL_BIT]),
		.tick(tick)
	);

	// Synchronised, noise-filtered pin with one-cycle edge pulses.
	tmr16_pinfilt u_filt (
		.hclk(hclk),
		.hresetn(hresetn),
		.pin(timer_input_pin),
		.level(pin_level),
		.rise(pin_rise),
		.fall(pin_fall)
	);

	// Zero-wait slave: every transfer completes in one data phase, OKAY.
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = rdata_ff;
	assign addr_phase = hsel && hready && htrans[1];

	// Latch the address phase of a write for use in its data phase.
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_ff <= 1'b0;
			waddr_ff <= 8'h00;
		end else if (hready) begin
			wr_ff <= addr_phase && hwrite;
			waddr_ff <= haddr;
		end
	end

	assign wr_ctrl = wr_ff && (waddr_ff == `TMR16_OFS_CTRL);
	assign wr_cmp_lo = wr_ff && (waddr_ff == `TMR16_OFS_CMP_LO);
	assign wr_cmp_hi = wr_ff && (waddr_ff == `TMR16_OFS_CMP_HI);
	assign wr_sec_lo = wr_ff && (waddr_ff == `TMR16_OFS_SEC_LO);
	assign wr_sec_hi = wr_ff && (waddr_ff == `TMR16_OFS_SEC_HI);
	assign wr_cmp_w = wr_ff && (waddr_ff == `TMR16_OFS_CMP_W);
	assign wr_sec_w = wr_ff && (waddr_ff == `TMR16_OFS_SEC_W);

	// Read data is prepared in the address phase so it stands from a flop.
	always @* begin
		nxt_rdata = 32'h00000000;
		case (haddr)
			`TMR16_OFS_CTRL: nxt_rdata = {21'h00000, ctrl_ff};
			`TMR16_OFS_CMP_LO: nxt_rdata = {24'h000000, cmp_act_ff[7:0]};
			`TMR16_OFS_CMP_HI: nxt_rdata = {24'h000000, cmp_act_ff[15:8]};
			`TMR16_OFS_SEC_LO: nxt_rdata = {24'h000000, sec_act_ff[7:0]};
			`TMR16_OFS_SEC_HI: nxt_rdata = {24'h000000, sec_act_ff[15:8]};
			`TMR16_OFS_CMP_W: nxt_rdata = {16'h0000, cmp_act_ff};
			`TMR16_OFS_SEC_W: nxt_rdata = {16'h0000, sec_act_ff};
			`TMR16_OFS_STAT: nxt_rdata = {13'h000, sec_pend_ff, cmp_pend_ff, run_ff, cnt_ff};
			default: nxt_rdata = 32'h00000000;
		endcase
	end

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rdata_ff <= 32'h00000000;
		end else if (addr_phase && !hwrite) begin
			rdata_ff <= nxt_rdata;
		end
	end

	// Control register. Mode, clock select, TFF and PSEL are locked while the timer
	// runs (START, ACAP and METT stay writable), which protects the counter from a half-changed setup.
	// STOP entry wins over a software write in the same cycle.
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl_ff <= `TMR16_CTRL_RST;
		end else begin
			if (wr_ctrl) begin
				ctrl_ff[`TMR16_START_MSB:`TMR16_START_LSB] <=
					hwdata[`TMR16_START_MSB:`TMR16_START_LSB];
				ctrl_ff[`TMR16_ACAP_BIT] <= hwdata[`TMR16_ACAP_BIT];
				ctrl_ff[`TMR16_METT_BIT] <= hwdata[`TMR16_METT_BIT];
				if (!running) begin
					ctrl_ff[`TMR16_CK_MSB:`TMR16_MODE_LSB] <=
						hwdata[`TMR16_CK_MSB:`TMR16_MODE_LSB];
					ctrl_ff[`TMR16_TFF_BIT] <= hwdata[`TMR16_TFF_BIT];
					ctrl_ff[`TMR16_PSEL_BIT] <= hwdata[`TMR16_PSEL_BIT];
				end
			end
			if (stop_mode_req) begin
				ctrl_ff[`TMR16_START_MSB:`TMR16_START_LSB] <= `TMR16_S_STOP;
			end
		end
	end

	// Timer registers: lower byte only fills the shift buffer; the upper
	// byte arms the transfer, done at the next source tick. A new write
	// arriving with the tick keeps the pending flag set.
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cmp_buf_ff <= 16'h0000;
			cmp_act_ff <= 16'h0000;
			cmp_pend_ff <= 1'b0;
			sec_buf_ff <= 16'h0000;
			sec_pend_ff <= 1'b0;
		end else begin
			if (wr_cmp_lo) begin
				cmp_buf_ff[7:0] <= hwdata[7:0];
			end
			if (wr_cmp_hi) begin
				cmp_buf_ff[15:8] <= hwdata[7:0];
			end
			if (wr_cmp_w) begin
				cmp_buf_ff <= hwdata[15:0];
			end
			if (wr_sec_lo) begin
				sec_buf_ff[7:0] <= hwdata[7:0];
			end
			if (wr_sec_hi) begin
				sec_buf_ff[15:8] <= hwdata[7:0];
			end
			if (wr_sec_w) begin
				sec_buf_ff <= hwdata[15:0];
			end
			if (tick && cmp_pend_ff) begin
				cmp_act_ff <= cmp_buf_ff;
			end
			cmp_pend_ff <= wr_cmp_hi || wr_cmp_w || (cmp_pend_ff && !tick);
			sec_pend_ff <= wr_sec_hi || wr_sec_w || (sec_pend_ff && !tick);
		end
	end

	// Counter next state per mode.
	always @* begin
		nxt_cnt = cnt_ff;
		nxt_run = run_ff;
		nxt_irq = 1'b0;
		cap_ev = 1'b0;
		if (!running) begin
			nxt_run = 1'b0;
		end else begin
			case (mode)
				`TMR16_M_TIMER: begin
					if (tick) begin
						cap_ev = 1'b1;
						if (at_match) begin
							nxt_cnt = 16'h0000;
							nxt_irq = 1'b1;
						end else begin
							nxt_cnt = cnt_inc;
						end
					end
				end
				`TMR16_M_EXTTRIG: begin
					if (!run_ff) begin
						if (trig_edge) begin
							nxt_run = 1'b1;
							nxt_cnt = 16'h0000;
						end
					end else if (tick && at_match) begin
						nxt_cnt = 16'h0000;
						nxt_run = 1'b0;
						nxt_irq = 1'b1;
					end else if (mett && opp_edge) begin
						nxt_cnt = 16'h0000;
						nxt_run = 1'b0;
					end else if (tick) begin
						nxt_cnt = cnt_inc;
					end
				end
				`TMR16_M_EVENT: begin
					if (trig_edge) begin
						cap_ev = 1'b1;
						nxt_cnt = cnt_inc;
					end else if (opp_edge && at_match) begin
						nxt_cnt = 16'h0000;
						nxt_irq = 1'b1;
					end
				end
				`TMR16_M_WINDOW: begin
					if (tick && (pin_level == trig_rise)) begin
						cap_ev = 1'b1;
						if (at_match) begin
							nxt_cnt = 16'h0000;
							nxt_irq = 1'b1;
						end else begin
							nxt_cnt = cnt_inc;
						end
					end
				end
				default: begin
					nxt_cnt = cnt_ff;
				end
			endcase
		end
	end

	// Counter, run flag and the one-cycle match pulse.
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt_ff <= 16'h0000;
			run_ff <= 1'b0;
			irq_ff <= 1'b0;
		end else begin
			cnt_ff <= nxt_cnt;
			run_ff <= nxt_run;
			irq_ff <= nxt_irq;
		end
	end

	// Second register: capture overrides a pending software value, since
	// in capture the register is owned by the hardware.
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sec_act_ff <= 16'h0000;
		end else if (acap && cap_mode && cap_ev) begin
			sec_act_ff <= cnt_ff;
		end else if (tick && sec_pend_ff) begin
			sec_act_ff <= sec_buf_ff;
		end
	end

	assign match_interrupt = irq_ff;
endmodule

// file: tmr16_pulse_src.sv
`timescale 1ns/100ps

module tmr16_pulse_src (
	input wire hclk,
	output reg pin
);
	// The pin starts low; after a drive it keeps the last level driven.
	initial pin = 1'b0;

	// Holds one level for n cycles; shorter requests are stretched to two cycles.
	task drive(input reg lvl, input integer n);
		pin <= lvl;
		repeat ((n < 2) ? 2 : n) @(posedge hclk);
	endtask
endmodule

// file: tmr16_top_assertions.sv
`timescale 1ns/100ps
`include "tmr16_defines.vh"

module tmr16_top_chk (
	input wire hclk,
	input wire hresetn,
	input wire hsel,
	input wire [7:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	input wire hreadyout,
	input wire [31:0] hrdata,
	input wire hresp,
	input wire timer_input_pin,
	input wire stop_mode_req,
	input wire match_interrupt
);
	reg [10:0] ctl_ff;
	reg wr_ff;
	reg pin_ff;
	reg [4:0] quiet_ff;

	// Shadow of the control word, so the mode is known without seeing inside.
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctl_ff <= 11'h000;
			wr_ff <= 1'b0;
		end else begin
			wr_ff <= hsel && hready && htrans[1] && hwrite && haddr == 8'h00;
			if (wr_ff)
				ctl_ff <= hwdata[10:0];
		end
	end

	// Cycles since the pin last moved; saturates far beyond the filter delay.
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pin_ff <= 1'b0;
			quiet_ff <= 5'h00;
		end else begin
			pin_ff <= timer_input_pin;
			quiet_ff <= (pin_ff != timer_input_pin) ? 5'h00 : quiet_ff + (quiet_ff != 5'h1F);
		end
	end

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	a_resp_okay: assert property (hresp == 1'b0) else $error("slave response not OKAY");
	a_zero_wait: assert property (hreadyout == 1'b1) else $error("wait state inserted");
	a_irq_pulse: assert property (match_interrupt |=> $fell(match_interrupt))
		else $error("interrupt longer than one cycle");
	a_irq_spacing: assert property (match_interrupt |=> !match_interrupt [*2])
		else $error("interrupts closer than a compare period allows");
	a_stop_halts: assert property (stop_mode_req [*3] |-> !match_interrupt)
		else $error("interrupt while in stop");
	a_stop_clears: assert property ($past(stop_mode_req) && hsel && hready && htrans[1]
		&& !hwrite && haddr == 8'h00 |=> hrdata[6:5] == 2'h0) else $error("start kept in stop");
	a_idle_quiet: assert property (ctl_ff[6:5] == 2'h0 && $past(ctl_ff[6:5]) == 2'h0
		|-> !match_interrupt) else $error("interrupt while stopped");
	a_event_edge: assert property ($stable(ctl_ff) && ctl_ff[2:0] == `TMR16_M_EVENT
		&& quiet_ff == 5'h1F |-> !match_interrupt) else $error("event match without edge");

	c_timer: cover property (match_interrupt && ctl_ff[2:0] == `TMR16_M_TIMER);
	c_event: cover property (match_interrupt && ctl_ff[2:0] == `TMR16_M_EVENT);
	c_trig: cover property (match_interrupt && ctl_ff[2:0] == `TMR16_M_EXTTRIG);
endmodule

bind tmr16_top tmr16_top_chk chk_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
	.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
	.hready(hready), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
	.timer_input_pin(timer_input_pin), .stop_mode_req(stop_mode_req),
	.match_interrupt(match_interrupt));

// file: tb_tmr16_top.sv
`timescale 1ns/100ps
`include "tmr16_defines.vh"

module tb_tmr16_top;
	reg hclk = 1'b0;
	reg hresetn = 1'b0;
	reg hsel = 1'b0;
	reg [7:0] haddr = 8'h00;
	reg [1:0] htrans = 2'h0;
	reg hwrite = 1'b0;
	reg [2:0] hsize = 3'h2;
	reg [31:0] hwdata = 32'h0;
	reg stop_mode_req = 1'b0;
	reg [31:0] rd;
	wire hready;
	wire [31:0] hrdata;
	wire hresp;
	wire pin;
	wire match_interrupt;
	integer n_fail = 0;
	integer cmp_count = 0;
	integer n_irq = 0;

	// Free-running bus clock.
	always #5 hclk = ~hclk;

	// Interrupt pulses are tallied so scenarios can compare counts.
	always @(posedge hclk) begin
		if (match_interrupt === 1'b1)
			n_irq <= n_irq + 1;
	end

	tmr16_top dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
		.hreadyout(hready), .hrdata(hrdata), .hresp(hresp), .timer_input_pin(pin),
		.stop_mode_req(stop_mode_req), .match_interrupt(match_interrupt));
	tmr16_pulse_src src_u (.hclk(hclk), .pin(pin));

	task check(input [31:0] seen, input [31:0] exp);
		cmp_count = cmp_count + 1;
		if (seen !== exp) begin
			n_fail = n_fail + 1;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task tick(input integer n);
		repeat (n) @(posedge hclk);
	endtask

	// One single-word transfer; the master never assumes a latency.
	task bus(input reg w, input [7:0] a, input [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		@(posedge hclk);
		while (hready !== 1'b1) @(posedge hclk);
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= d;
		@(posedge hclk);
		while (hready !== 1'b1) @(posedge hclk);
		rd = hrdata;
	endtask

	// Counts edges until the next interrupt pulse, giving up after a bound.
	task wait_irq(output integer n);
		n = 0;
		do begin
			@(posedge hclk);
			n = n + 1;
		end while (match_interrupt !== 1'b1 && n < 200);
	endtask

	// A mid-run reset returns the counter to zero between modes.
	task rst;
		hresetn <= 1'b0;
		tick(2);
		hresetn <= 1'b1;
		tick(1);
	endtask

	task t_regs;
		bus(0, `TMR16_OFS_CTRL, 0);
		check(rd, 32'h0);
		check(hresp, 32'h0);
		bus(1, `TMR16_OFS_CTRL, 32'h18);
		bus(1, `TMR16_OFS_CMP_LO, 32'h05);
		tick(3);
		bus(0, `TMR16_OFS_CMP_LO, 0);
		check(rd, 32'h0);
		bus(1, `TMR16_OFS_CMP_HI, 32'h01);
		tick(3);
		bus(0, `TMR16_OFS_CMP_W, 0);
		check(rd, 32'h105);
		bus(0, 8'h20, 0);
		check(rd, 32'h0);
		bus(0, `TMR16_OFS_CTRL, 0);
		check(rd, 32'h18);
	endtask

	task t_timer;
		integer n;
		reg [31:0] s;
		bus(1, `TMR16_OFS_CMP_W, 32'h3);
		bus(1, `TMR16_OFS_CTRL, 32'hB8);
		wait_irq(n);
		wait_irq(n);
		check(n, 4);
		bus(0, `TMR16_OFS_SEC_W, 0);
		check(rd <= 32'h3, 1'b1);
		stop_mode_req <= 1'b1;
		tick(3);
		stop_mode_req <= 1'b0;
		bus(0, `TMR16_OFS_CTRL, 0);
		check(rd, 32'h98);
		bus(0, `TMR16_OFS_STAT, 0);
		s = rd;
		tick(9);
		bus(0, `TMR16_OFS_STAT, 0);
		check(rd, s);
	endtask

	task t_event;
		integer k;
		rst;
		bus(1, `TMR16_OFS_CTRL, 32'h1A);
		bus(1, `TMR16_OFS_CMP_W, 32'h2);
		bus(1, `TMR16_OFS_CTRL, 32'h3A);
		k = n_irq;
		src_u.drive(1, 4);
		src_u.drive(0, 20);
		bus(0, `TMR16_OFS_STAT, 0);
		check(rd[15:0], 16'h0);
		src_u.drive(1, 12);
		src_u.drive(0, 20);
		src_u.drive(1, 16);
		bus(0, `TMR16_OFS_STAT, 0);
		check(rd[15:0], 16'h2);
		check(n_irq, k);
		src_u.drive(0, 20);
		check(n_irq, k + 1);
		bus(0, `TMR16_OFS_STAT, 0);
		check(rd[15:0], 16'h0);
		// Window mode counts ticks only while the pin is high; a 20-cycle window
		// with compare 2 gives six matches and leaves the counter at two.
		bus(1, `TMR16_OFS_CTRL, 32'h1A);
		bus(1, `TMR16_OFS_CTRL, 32'h3B);
		k = n_irq;
		tick(20);
		bus(0, `TMR16_OFS_STAT, 0);
		check(rd[15:0], 16'h0);
		src_u.drive(1, 20);
		src_u.drive(0, 20);
		check(n_irq, k + 6);
		bus(0, `TMR16_OFS_STAT, 0);
		check(rd[15:0], 16'h2);
	endtask

	task t_trig;
		integer k;
		rst;
		bus(1, `TMR16_OFS_CMP_W, 32'h20);
		bus(1, `TMR16_OFS_CTRL, 32'h199);
		bus(1, `TMR16_OFS_CTRL, 32'h1B9);
		k = n_irq;
		src_u.drive(1, 20);
		bus(0, `TMR16_OFS_STAT, 0);
		check(rd[16], 1'b1);
		src_u.drive(0, 40);
		check(n_irq, k);
		bus(0, `TMR16_OFS_STAT, 0);
		check(rd[15:0], 16'h0);
		src_u.drive(1, 60);
		check(n_irq, k + 1);
		bus(0, `TMR16_OFS_SEC_W, 0);
		check(rd, 32'h0);
		bus(1, `TMR16_OFS_CTRL, 32'h099);
		bus(1, `TMR16_OFS_CTRL, 32'h0B9);
		src_u.drive(0, 12);
		src_u.drive(1, 14);
		// A second trigger edge before the match must not restart the count.
		src_u.drive(0, 12);
		src_u.drive(1, 14);
		src_u.drive(0, 8);
		check(n_irq, k + 2);
		src_u.drive(0, 40);
		check(n_irq, k + 2);
	endtask

	task test_done;
		if (n_fail == 0 && cmp_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// A hang anywhere ends the run as a failure.
	initial begin
		#20000;
		n_fail = n_fail + 1;
		test_done;
	end

	initial begin
		tick(5);
		hresetn <= 1'b1;
		tick(1);
		t_regs;
		t_timer;
		t_event;
		t_trig;
		test_done;
	end
endmodule
